// *** verilog/gcsw_pkg.sv ***
// Constants shared by the gateway control/status word block.
// Assumes byte-wide access to the fieldbus input and output data areas.

package gcsw_pkg;

  // ----------------------------------------------------------------
  // Byte addresses of the two words inside the data areas
  // ----------------------------------------------------------------
  localparam logic [9:0] ADDR_STAT_HI = 10'h000;
  localparam logic [9:0] ADDR_STAT_LO = 10'h001;
  localparam logic [9:0] ADDR_CTRL_HI = 10'h200;
  localparam logic [9:0] ADDR_CTRL_LO = 10'h201;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_TX_BIT = 15;
  localparam int STAT_ACK_BIT = 14;
  localparam int STAT_DV_BIT = 13;
  localparam int CTRL_ACK_BIT = 15;
  localparam int CTRL_TX_BIT = 14;
  localparam int CTRL_DV_BIT = 13;
  localparam int CTRL_EXEC_BIT = 12;
  localparam int CODE_LSB = 8;

  // ----------------------------------------------------------------
  // Status report codes (master modes) and control codes
  // ----------------------------------------------------------------
  localparam logic [4:0] SC_RETX = 5'h00;
  localparam logic [4:0] SC_MISS_ONE = 5'h01;
  localparam logic [4:0] SC_MISS_MANY = 5'h02;
  localparam logic [4:0] SC_OVERRUN = 5'h03;
  localparam logic [4:0] SC_OTHER = 5'h04;
  localparam logic [4:0] SC_NO_ERROR = 5'h1F;
  localparam logic [3:0] CC_NODE_OFF = 4'h0;
  localparam logic [3:0] CC_NODE_ON = 4'h1;
  localparam logic [3:0] CC_FIRST_N = 4'h2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] STAT_CODE_RST = 5'h1F;
  localparam logic [7:0] STAT_DATA_RST = 8'h00;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Operating modes and fieldbus participation states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MASTER = 2'h0,
    MODE_DF1_MASTER = 2'h1,
    MODE_GENERIC = 2'h2
  } gcsw_mode_t;

  typedef enum logic [2:0] {
    ST_OFFLINE = 3'b001,
    ST_WAIT = 3'b010,
    ST_EXCHANGE = 3'b100
  } gcsw_state_t;

endpackage

// *** verilog/gcsw_rpt_if.sv ***
// Carrier for one status report from the event encoder to the word logic.
// Assumes both ends share one clock; new_rpt is a one-cycle pulse.

`timescale 1ns/10ps

interface gcsw_rpt_if;
  logic new_rpt;
  logic [4:0] code;
  logic [7:0] data;
  modport src (output new_rpt, output code, output data);
  modport sink (input new_rpt, input code, input data);
endinterface

// *** verilog/gcsw_evt_report.sv ***
// Turns subnetwork events into status report codes for the master modes.
// Assumes event pulses last one cycle and counts are levels.

`timescale 1ns/10ps

module gcsw_evt_report
  import gcsw_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic is_master, // Master or DF1 master mode
  input wire logic [7:0] miss_cnt, // Nodes currently missing
  input wire logic [7:0] miss_addr, // Address of a single missing node
  input wire logic retx_pulse, // Retransmission counter went up
  input wire logic [7:0] retx_cnt, // Retransmission counter value
  input wire logic ovr_pulse, // A node returned too much data
  input wire logic [7:0] ovr_addr, // Node that overran
  input wire logic oth_pulse, // Undefined error seen
  input wire logic [7:0] oth_addr, // Node of the undefined error
  input wire logic cycle_ok, // Clean subnetwork cycle finished
  gcsw_rpt_if.src rpt // Report towards the word logic
);

  // ----------------------------------------------------------------
  // Error tracking
  // ----------------------------------------------------------------
  logic [7:0] miss_prev_reg;
  logic oth_err_reg;
  logic fire;
  logic [4:0] code_next;
  logic [7:0] data_next;

  wire miss_chg = miss_cnt != miss_prev_reg;
  wire oth_clear = oth_err_reg & cycle_ok & ~oth_pulse;

  // Priority: missing nodes, undefined error, overrun, retransmission
  always_comb begin
    fire = is_master;
    code_next = SC_NO_ERROR;
    data_next = 8'h00;
    if (miss_chg && miss_cnt == 8'h01) begin
      code_next = SC_MISS_ONE;
      data_next = miss_addr;
    end else if (miss_chg && miss_cnt != 8'h00) begin
      code_next = SC_MISS_MANY;
      data_next = miss_cnt;
    end else if (oth_pulse) begin
      code_next = SC_OTHER;
      data_next = oth_addr;
    end else if (miss_chg || oth_clear) begin
      // Only send all-clear when no other error is still standing
      fire = is_master & ~(oth_err_reg & ~oth_clear) & (miss_cnt == 8'h00);
    end else if (ovr_pulse) begin
      code_next = SC_OVERRUN;
      data_next = ovr_addr;
    end else if (retx_pulse) begin
      code_next = SC_RETX;
      data_next = retx_cnt;
    end else begin
      fire = 1'b0;
    end
  end

  // Register the report so the word logic sees a clean pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miss_prev_reg <= 8'h00;
      oth_err_reg <= 1'b0;
      rpt.new_rpt <= 1'b0;
      rpt.code <= STAT_CODE_RST;
      rpt.data <= STAT_DATA_RST;
    end else begin
      miss_prev_reg <= miss_cnt;
      oth_err_reg <= oth_pulse | (oth_err_reg & ~oth_clear);
      rpt.new_rpt <= fire;
      rpt.code <= code_next;
      rpt.data <= data_next;
    end
  end

endmodule

// *** verilog/gcsw_top.sv ***
// Gateway control and status words: handshake, data-valid lock, reports.
// Assumes byte access from the fieldbus side and synchronous inputs.
//
// Overview of operation
// - Words stay off unless enabled; those bytes are then plain data.
// - Status word at input bytes 0x000-0x001, control at 0x200-0x201.
// - Words are held most significant byte first.
// - Status bit 15 is the send flag, bit 14 the confirm flag.
// - Both sides use the send/confirm handshake on the words.
// - Master modes: status data-valid set once all transactions succeeded.
// - Status data-valid never clears while online in a master mode.
// - Generic mode leaves status data-valid unused.
// - Status bits 12..8 hold the last code, bits 7..0 its data.
// - Code 0x00 warns of a higher retransmission count.
// - Code 0x01 reports one missing node with its address.
// - Code 0x02 reports several missing nodes with their count.
// - Code 0x03 warns of overrun, 0x04 reports undefined error.
// - Resolved errors are followed by code 0x1F.
// - With startup lock, no subnetwork traffic until control data-valid.
// - Without lock, subnetwork traffic starts as soon as online.
// - With startup lock, control data-valid one allows exchange, zero stops it.
// - Control codes disable, enable, or enable first N nodes.

`timescale 1ns/10ps

module gcsw_top
  import gcsw_pkg::*;
#(
  parameter int ADDR_W = 10 // Byte address width of the data areas
) (
  input wire logic CLK_SYS, // System clock, 200 MHz
  input wire logic RESETN, // Asynchronous reset, active low
  input wire logic CFG_WORDS_EN, // Control/status words enabled
  input wire logic CFG_STARTUP_LOCK, // Startup lock on data-valid
  input wire logic [1:0] CFG_MODE, // Operating mode
  input wire logic FB_ONLINE, // Fieldbus is online
  input wire logic [ADDR_W-1:0] FB_ADDR, // Byte address from fieldbus side
  input wire logic FB_WR, // Byte write strobe
  input wire logic FB_RD, // Byte read strobe
  input wire logic [7:0] FB_WDATA, // Write byte
  output logic [7:0] FB_RDATA, // Read byte, one cycle after FB_RD
  output logic FB_RHIT, // Read byte came from a word
  input wire logic SUB_ALL_DONE, // Every transaction done once
  input wire logic SUB_CYCLE_OK, // A clean subnetwork cycle ended
  input wire logic SUB_RETX_PULSE, // Retransmission counter rose
  input wire logic [7:0] SUB_RETX_CNT, // Retransmission counter
  input wire logic [7:0] SUB_MISS_CNT, // Missing node count
  input wire logic [7:0] SUB_MISS_ADDR, // Single missing node address
  input wire logic SUB_OVR_PULSE, // Overrun seen
  input wire logic [7:0] SUB_OVR_ADDR, // Overrun node address
  input wire logic SUB_OTH_PULSE, // Undefined error seen
  input wire logic [7:0] SUB_OTH_ADDR, // Undefined error node address
  output logic SUB_RUN, // Subnetwork exchange allowed
  output logic NODE_CMD_VALID, // Node command pulse
  output logic [3:0] NODE_CMD_CODE, // Node command code
  output logic [7:0] NODE_CMD_ARG, // Node address or count
  output logic STAT_DATA_VALID // Copy of status data-valid bit
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W too narrow for the control word address");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  gcsw_state_t state_reg, state_next;
  logic [15:0] ctrl_reg;
  logic gw_handshake_tx_flag, gw_handshake_ack_flag, sdv_reg;
  logic [4:0] scode_reg;
  logic [7:0] sdata_reg;
  logic pend_reg;
  logic [4:0] pend_code_reg;
  logic [7:0] pend_data_reg;
  logic [7:0] rdata_next;
  gcsw_rpt_if rpt_if ();

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_master = CFG_MODE != MODE_GENERIC;
  wire [9:0] addr = FB_ADDR[9:0];
  wire hi_zero = (ADDR_W == 10) ? 1'b1 : (FB_ADDR >> 10) == '0;
  // Word addresses only decode while the words are enabled
  wire sel_shi = CFG_WORDS_EN & hi_zero & (addr == ADDR_STAT_HI);
  wire sel_slo = CFG_WORDS_EN & hi_zero & (addr == ADDR_STAT_LO);
  wire sel_chi = CFG_WORDS_EN & hi_zero & (addr == ADDR_CTRL_HI);
  wire sel_clo = CFG_WORDS_EN & hi_zero & (addr == ADDR_CTRL_LO);
  wire rd_hit = FB_RD & (sel_shi | sel_slo | sel_chi | sel_clo);
  wire host_handshake_tx_flag = ctrl_reg[CTRL_TX_BIT];
  wire host_handshake_ack_flag = ctrl_reg[CTRL_ACK_BIT];
  wire ctrl_dv = ctrl_reg[CTRL_DV_BIT];
  // Status word image, flags on top
  wire [15:0] stat_word = {gw_handshake_tx_flag, gw_handshake_ack_flag, sdv_reg,
                           scode_reg, sdata_reg};

  // Read data: even address carries the upper byte
  always_comb begin
    rdata_next = 8'h00;
    if (sel_shi) rdata_next = stat_word[15:8];
    if (sel_slo) rdata_next = stat_word[7:0];
    if (sel_chi) rdata_next = ctrl_reg[15:8];
    if (sel_clo) rdata_next = ctrl_reg[7:0];
  end

  // ----------------------------------------------------------------
  // Fieldbus participation
  // ----------------------------------------------------------------
  // Lock holds traffic until the host marks outputs valid
  wire go = ~CFG_WORDS_EN | ~CFG_STARTUP_LOCK | ctrl_dv;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFFLINE: if (FB_ONLINE) state_next = go ? ST_EXCHANGE : ST_WAIT;
      ST_WAIT: begin
        if (!FB_ONLINE) state_next = ST_OFFLINE;
        else if (go) state_next = ST_EXCHANGE;
      end
      ST_EXCHANGE: begin
        if (!FB_ONLINE) state_next = ST_OFFLINE;
        else if (!go) state_next = ST_WAIT;
      end
      default: state_next = ST_OFFLINE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= ST_OFFLINE;
      SUB_RUN <= 1'b0;
    end else begin
      state_reg <= state_next;
      SUB_RUN <= state_next == ST_EXCHANGE;
    end
  end

  // ----------------------------------------------------------------
  // Control word capture, byte by byte
  // ----------------------------------------------------------------
  // Writes are dropped while disabled so the area stays plain data
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      if (FB_WR && sel_chi) ctrl_reg[15:8] <= FB_WDATA;
      if (FB_WR && sel_clo) ctrl_reg[7:0] <= FB_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Host-to-gateway handshake and command execution
  // ----------------------------------------------------------------
  // A new host word shows as a send flag that differs from our confirm
  wire host_new = CFG_WORDS_EN & (host_handshake_tx_flag != gw_handshake_ack_flag);
  wire exec_ok = host_new & is_master & ctrl_reg[CTRL_EXEC_BIT] &
                 (ctrl_reg[11:8] <= CC_FIRST_N);

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      gw_handshake_ack_flag <= 1'b0;
      NODE_CMD_VALID <= 1'b0;
      NODE_CMD_CODE <= CC_NODE_OFF;
      NODE_CMD_ARG <= 8'h00;
    end else begin
      if (host_new) gw_handshake_ack_flag <= host_handshake_tx_flag;
      NODE_CMD_VALID <= exec_ok;
      if (exec_ok) begin
        NODE_CMD_CODE <= ctrl_reg[11:8];
        NODE_CMD_ARG <= ctrl_reg[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Report encoder
  // ----------------------------------------------------------------
  gcsw_evt_report u_rpt (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .is_master(is_master),
    .miss_cnt(SUB_MISS_CNT),
    .miss_addr(SUB_MISS_ADDR),
    .retx_pulse(SUB_RETX_PULSE),
    .retx_cnt(SUB_RETX_CNT),
    .ovr_pulse(SUB_OVR_PULSE),
    .ovr_addr(SUB_OVR_ADDR),
    .oth_pulse(SUB_OTH_PULSE),
    .oth_addr(SUB_OTH_ADDR),
    .cycle_ok(SUB_CYCLE_OK),
    .rpt(rpt_if.src)
  );

  // ----------------------------------------------------------------
  // Gateway-to-host handshake
  // ----------------------------------------------------------------
  // Only the latest report waits; older ones are overwritten, since the
  // host sees the last status anyway and a queue would only add latency.
  wire host_caught_up = host_handshake_ack_flag == gw_handshake_tx_flag;
  wire load = CFG_WORDS_EN & pend_reg & host_caught_up;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pend_reg <= 1'b0;
      pend_code_reg <= STAT_CODE_RST;
      pend_data_reg <= STAT_DATA_RST;
    end else begin
      // A new report in the load cycle stays pending: set wins
      pend_reg <= rpt_if.new_rpt | (pend_reg & ~load);
      if (rpt_if.new_rpt) begin
        pend_code_reg <= rpt_if.code;
        pend_data_reg <= rpt_if.data;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      gw_handshake_tx_flag <= 1'b0;
      scode_reg <= STAT_CODE_RST;
      sdata_reg <= STAT_DATA_RST;
    end else if (load) begin
      gw_handshake_tx_flag <= ~gw_handshake_tx_flag;
      scode_reg <= pend_code_reg;
      sdata_reg <= pend_data_reg;
    end
  end

  // ----------------------------------------------------------------
  // Status data-valid and read port
  // ----------------------------------------------------------------
  // Sticky while online in a master mode; going offline or to generic mode clears it
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sdv_reg <= 1'b0;
      STAT_DATA_VALID <= 1'b0;
      FB_RDATA <= 8'h00;
      FB_RHIT <= 1'b0;
    end else begin
      sdv_reg <= is_master & FB_ONLINE & (sdv_reg | SUB_ALL_DONE);
      STAT_DATA_VALID <= is_master & FB_ONLINE & (sdv_reg | SUB_ALL_DONE);
      FB_RDATA <= rd_hit ? rdata_next : 8'h00;
      FB_RHIT <= rd_hit;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_dv_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    sdv_reg && FB_ONLINE && is_master |=> sdv_reg)
    else $error("status data-valid dropped while online");
  a_dv_generic: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !is_master |=> !sdv_reg)
    else $error("status data-valid used in generic mode");
  a_dv_set: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    SUB_ALL_DONE && is_master && FB_ONLINE |=> sdv_reg && STAT_DATA_VALID)
    else $error("status data-valid not set after all transactions");
  a_disabled_quiet: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !CFG_WORDS_EN |=> !FB_RHIT && $stable(ctrl_reg))
    else $error("disabled words still answer or capture");
  a_lock_holds: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    CFG_WORDS_EN && CFG_STARTUP_LOCK && !ctrl_dv |=> !SUB_RUN)
    else $error("subnetwork ran before control data-valid");
  a_free_start: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    FB_ONLINE && (!CFG_WORDS_EN || !CFG_STARTUP_LOCK) |=> SUB_RUN)
    else $error("subnetwork did not start on online");
  a_byte_order: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    FB_RD && sel_shi |=> FB_RHIT && FB_RDATA == $past(stat_word[15:8]))
    else $error("status upper byte not at even address");
  a_tx_waits: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    $changed(gw_handshake_tx_flag) |-> $past(host_caught_up) && $past(pend_reg))
    else $error("send flag toggled before host confirm");
  a_ack_copy: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    host_new |=> gw_handshake_ack_flag == $past(host_handshake_tx_flag))
    else $error("confirm flag did not copy host send flag");
  a_rpt_load: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    load |=> scode_reg == $past(pend_code_reg) && sdata_reg == $past(pend_data_reg))
    else $error("report not placed in status fields");
  a_cmd_exec: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    exec_ok |=> NODE_CMD_VALID && NODE_CMD_CODE == $past(ctrl_reg[11:8]) ##1 !NODE_CMD_VALID
      || !$past(exec_ok, 1) )
    else $error("node command not issued once");
  // Refused codes are only confirmed, never turned into a command
  a_cmd_refused: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    host_new && !exec_ok |=> !NODE_CMD_VALID)
    else $error("refused control code issued a command");
  a_offline_idle: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !FB_ONLINE |=> !SUB_RUN)
    else $error("subnetwork ran while offline");

  c_cmd: cover property (@(posedge CLK_SYS) disable iff (!RESETN) NODE_CMD_VALID);
  c_dv_set: cover property (@(posedge CLK_SYS) disable iff (!RESETN) $rose(sdv_reg));
  c_report: cover property (@(posedge CLK_SYS) disable iff (!RESETN) load ##1 host_new);
  c_lock_run: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
    state_reg == ST_WAIT ##1 state_reg == ST_EXCHANGE);

endmodule

// *** verif/gcsw_plc_model.sv ***
// Control system model: byte access to the data areas, word handshakes.
// Assumes registered read answers; strobes move at the falling edge.
`timescale 1ns/10ps
module gcsw_plc_model
  import gcsw_pkg::*;
(
  input wire logic clk, // System clock
  output logic [9:0] addr, // Byte address
  output logic wr, // Write strobe
  output logic rd, // Read strobe
  output logic [7:0] wdata, // Write byte
  input wire logic [7:0] rdata, // Read byte
  input wire logic rhit // Read hit
);
  // ---------------------------------------------
  // Byte cycles, held across one rising edge
  // ---------------------------------------------
  logic [15:0] ctrl_reg = CTRL_RST; // Data-valid starts clear
  initial begin
    addr = 10'h3FF;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'hFF;
  end
  // Released lines flip so a stale value never looks valid
  task automatic put(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic get(input logic [9:0] a, output logic [7:0] d, output logic h);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = rdata;
    h = rhit;
  endtask
  // ---------------------------------------------
  // Word handshakes
  // ---------------------------------------------
  task automatic get_word(output logic [15:0] w, output logic h);
    logic h1;
    get(ADDR_STAT_HI, w[15:8], h);
    get(ADDR_STAT_LO, w[7:0], h1);
  endtask
  // Low byte first, flags byte last, then wait for the copy
  task automatic send(input logic [13:0] f, output logic ok);
    logic [15:0] s;
    logic h;
    ctrl_reg[13:0] = f;
    ctrl_reg[14] = ~ctrl_reg[14];
    put(ADDR_CTRL_LO, ctrl_reg[7:0]);
    put(ADDR_CTRL_HI, ctrl_reg[15:8]);
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      get_word(s, h);
      ok = (s[14] === ctrl_reg[14]);
    end
  endtask
  task automatic confirm(input logic [15:0] s);
    ctrl_reg[15] = s[15];
    put(ADDR_CTRL_HI, ctrl_reg[15:8]);
  endtask
  // Offline: drop data-valid and write the flags byte
  task automatic go_offline();
    ctrl_reg[13] = 1'b0;
    put(ADDR_CTRL_HI, ctrl_reg[15:8]);
  endtask
  // Data-valid goes up only once the status copy is seen clear
  // Returns on the confirm; status data-valid is never awaited
  task automatic go_online(output logic ok);
    logic [15:0] s;
    logic h;
    get_word(s, h);
    ok = 1'b0;
    if (s[13] === 1'b0) send({1'b1, 13'h0}, ok);
  endtask
endmodule

// *** verif/gcsw_top_tb_top.sv ***
// Self-checking bench for the control and status words.
// Assumes the control system model drives the fieldbus byte port.
`timescale 1ns/10ps
module gcsw_top_tb_top;
  logic clk_sys, resetn, cfg_words_en, cfg_startup_lock, fb_online, fb_wr, fb_rd, fb_rhit;
  logic sub_all_done, sub_cycle_ok, sub_retx_pulse, sub_ovr_pulse, sub_oth_pulse;
  logic sub_run, node_cmd_valid, stat_data_valid, h, ok, exp_tx;
  logic [1:0] cfg_mode;
  logic [3:0] node_cmd_code;
  logic [9:0] fb_addr;
  logic [7:0] fb_wdata, fb_rdata, sub_retx_cnt, sub_miss_cnt, sub_miss_addr;
  logic [7:0] sub_ovr_addr, sub_oth_addr, node_cmd_arg;
  logic [15:0] s;
  int fails = 0;
  int samples_checked = 0;
  int cmd_cnt = 0;
  int n;
  gcsw_top i_gcsw_top (.CLK_SYS(clk_sys), .RESETN(resetn), .CFG_WORDS_EN(cfg_words_en),
    .CFG_STARTUP_LOCK(cfg_startup_lock), .CFG_MODE(cfg_mode), .FB_ONLINE(fb_online),
    .FB_ADDR(fb_addr), .FB_WR(fb_wr), .FB_RD(fb_rd), .FB_WDATA(fb_wdata), .FB_RDATA(fb_rdata),
    .FB_RHIT(fb_rhit), .SUB_ALL_DONE(sub_all_done), .SUB_CYCLE_OK(sub_cycle_ok),
    .SUB_RETX_PULSE(sub_retx_pulse), .SUB_RETX_CNT(sub_retx_cnt), .SUB_MISS_CNT(sub_miss_cnt),
    .SUB_MISS_ADDR(sub_miss_addr), .SUB_OVR_PULSE(sub_ovr_pulse), .SUB_OVR_ADDR(sub_ovr_addr),
    .SUB_OTH_PULSE(sub_oth_pulse), .SUB_OTH_ADDR(sub_oth_addr), .SUB_RUN(sub_run),
    .NODE_CMD_VALID(node_cmd_valid), .NODE_CMD_CODE(node_cmd_code),
    .NODE_CMD_ARG(node_cmd_arg), .STAT_DATA_VALID(stat_data_valid));
  gcsw_plc_model i_gcsw_plc_model (.clk(clk_sys), .addr(fb_addr), .wr(fb_wr), .rd(fb_rd),
    .wdata(fb_wdata), .rdata(fb_rdata), .rhit(fb_rhit));
  // ---------------------------------------------
  // Clock, command pulse counter, watchdog
  // ---------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (node_cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 1;
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end
  // ---------------------------------------------
  // Compare and stimulus helpers
  // ---------------------------------------------
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s got %b", $time, what, got);
    end
  endtask
  task automatic pulse(ref logic p);
    @(negedge clk_sys);
    p = 1'b1;
    @(negedge clk_sys);
    p = 1'b0;
  endtask
  // Status fields after a report; confirm flag masked, data-valid must stay
  task automatic expect_rpt(input logic [4:0] code, input logic [7:0] dat, input logic use_d);
    repeat (3) @(negedge clk_sys);
    i_gcsw_plc_model.get_word(s, h);
    exp_tx = ~exp_tx;
    chk_w(s & {8'hBF, {8{use_d}}}, {exp_tx, 2'b01, code, dat}, "report");
    i_gcsw_plc_model.confirm(s);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {resetn, cfg_words_en, cfg_startup_lock, fb_online, sub_all_done, sub_cycle_ok} = 6'h0;
    {sub_retx_pulse, sub_ovr_pulse, sub_oth_pulse, cfg_mode, exp_tx} = 6'h0;
    {sub_retx_cnt, sub_miss_cnt, sub_miss_addr, sub_ovr_addr, sub_oth_addr} = 40'h0;
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    fb_online = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_b(sub_run, 1'b1, "run unlocked");
    i_gcsw_plc_model.get_word(s, h);
    chk_b(h, 1'b0, "hit while off");
    i_gcsw_plc_model.put(10'h200, 8'hFF);
    {cfg_words_en, cfg_startup_lock} = 2'b11;
    repeat (2) @(negedge clk_sys);
    chk_b(sub_run, 1'b0, "run locked");
    i_gcsw_plc_model.get_word(s, h);
    chk_w(s, 16'h1F00, "status reset");
    i_gcsw_plc_model.go_online(ok);
    chk_b(ok, 1'b1, "valid confirmed");
    chk_b(sub_run, 1'b1, "run after valid");
    pulse(sub_all_done);
    repeat (2) @(negedge clk_sys);
    chk_b(stat_data_valid, 1'b1, "status valid");
    // Codes 0..2 run a node command, code 3 is only confirmed
    for (int k = 0; k < 4; k++) begin
      n = cmd_cnt;
      i_gcsw_plc_model.send({2'b11, k[3:0], 8'h10 + k[7:0]}, ok);
      chk_b(cmd_cnt == n + (k < 3), 1'b1, "cmd count");
      if (k < 3) chk_w({node_cmd_code, node_cmd_arg}, {k[3:0], 8'h10 + k[7:0]}, "cmd");
    end
    i_gcsw_plc_model.get(10'h200, s[15:8], h);
    i_gcsw_plc_model.get(10'h201, s[7:0], h);
    chk_w(s, 16'h7313, "control readback");
    chk_b(h, 1'b1, "hit while on");
    sub_miss_addr = 8'h21;
    sub_miss_cnt = 8'h01;
    expect_rpt(5'h01, 8'h21, 1'b1);
    sub_miss_cnt = 8'h03;
    expect_rpt(5'h02, 8'h03, 1'b1);
    sub_miss_cnt = 8'h00;
    expect_rpt(5'h1F, 8'h00, 1'b0);
    cfg_mode = 2'h1;
    sub_retx_cnt = 8'h05;
    pulse(sub_retx_pulse);
    expect_rpt(5'h00, 8'h05, 1'b1);
    sub_ovr_addr = 8'h33;
    pulse(sub_ovr_pulse);
    expect_rpt(5'h03, 8'h33, 1'b1);
    sub_oth_addr = 8'h44;
    pulse(sub_oth_pulse);
    expect_rpt(5'h04, 8'h44, 1'b1);
    pulse(sub_cycle_ok);
    expect_rpt(5'h1F, 8'h00, 1'b0);
    fb_online = 1'b0;
    i_gcsw_plc_model.go_offline();
    chk_b(sub_run, 1'b0, "run offline");
    chk_b(stat_data_valid, 1'b0, "valid offline");
    fb_online = 1'b1;
    i_gcsw_plc_model.go_online(ok);
    chk_b(ok & sub_run, 1'b1, "run after reonline");
    pulse(sub_all_done);
    cfg_mode = 2'h2;
    pulse(sub_ovr_pulse);
    repeat (3) @(negedge clk_sys);
    i_gcsw_plc_model.get_word(s, h);
    chk_w({3'h0, s[12:8], 8'h00}, 16'h1F00, "generic report");
    chk_b(stat_data_valid, 1'b0, "generic valid");
    conclude();
  end
endmodule
